// *** ethernet_mac_mii_rmii_mode_tb.sv ***
// Register-level regression of the MAC front end against the PHY model
`timescale 1ns/10ps
`default_nettype none
`include "etm_defs.svh"
module ethernet_mac_mii_rmii_mode_tb;
    logic        core_clk_i = 0;
    logic        resetn_i = 0;
    logic        reg_wr_i = 0;
    logic        reg_rd_i = 0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o, fcs;
    logic [7:0]  db = 8'hab;
    logic [3:0]  mii_txd_o, mii_rxd_i;
    logic [1:0]  rmii_txd_o, rmii_rxd_i;
    logic        irq_o, lck, mii_tx_en_o, rmii_tx_en_o, mii_rx_dv_i, mii_crs_i;
    logic        mdc_o, mdio_o, mdio_oe_n_o, mdio_i;
    int          failures = 0;
    int          cmp_count = 0;
    initial
    begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    etm_mac dut (.core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .irq_o, .mii_tx_clk_i(lck), .mii_rx_clk_i(lck), .mii_txd_o,
        .reduced_if_reference_clock_i(lck), .mii_tx_en_o, .transmit_coding_error_pin_o(),
        .mii_rxd_i, .mii_rx_dv_i, .mii_rx_er_i(1'b0), .mii_crs_i, .mii_col_i(1'b0),
        .rmii_txd_o, .rmii_tx_en_o, .rmii_rxd_i, .rmii_crs_dv_i(1'b0), .mdc_o, .mdio_o,
        .mdio_oe_n_o, .mdio_i);
    etm_phy_model phy (.lck_o(lck), .txd_i(mii_txd_o), .tx_en_i(mii_tx_en_o),
        .rtxd_i(rmii_txd_o), .rtx_en_i(rmii_tx_en_o), .rxd_o(mii_rxd_i), .mdc_i(mdc_o),
        .rx_dv_o(mii_rx_dv_i), .crs_o(mii_crs_i), .rrxd_o(rmii_rxd_i), .mdio_i(mdio_o),
        .mdio_oe_n_i(mdio_oe_n_o), .mdio_o(mdio_i));
    task automatic finish_test;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Masked read; data stands only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk($sformatf("reg %h", a), reg_rdata_o & m, e);
    endtask
    task automatic wirq(input int lim);
        for (int i = 0; i < lim && irq_o !== 1'b1; i++)
            @(posedge core_clk_i) #1;
        if (irq_o !== 1'b1)
        begin
            chk("irq wait", 32'h0, 32'h1);
            finish_test();
        end
    endtask
    // Units low bits first, each seen rep times; the PHY takes the tail a link edge late
    task automatic tx_chk(input int nb, rep, input logic [31:0] f);
        logic [103:0] v;
        v = {f, 8'hab, `ETM_SFD, {7{`ETM_PRE}}};
        repeat (80 * rep) @(posedge core_clk_i);
        chk("unit count", 32'(phy.q.size()), 32'(13 * nb * rep));
        for (int k = 0; k < 13 * nb; k++)
            chk("unit", 32'(phy.q[k * rep + rep / 2]),
                32'(v >> (k * 8 / nb)) & ((32'h1 << (8 / nb)) - 32'h1));
        phy.q.delete();
    endtask
    initial
    begin
        fcs = `ETM_CRC_INIT;
        for (int i = 0; i < 8; i++)
            fcs = (fcs >> 1) ^ ((fcs[0] ^ db[i]) ? `ETM_CRC_POLY : 32'h0);
        fcs = ~fcs;
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rc(`ETM_A_CTRL, '1, 32'h20);
        rc(`ETM_A_MASK, '1, 32'h0);
        rc(8'h40, '1, 32'h0);
        wr(`ETM_A_MASK, 32'h1);
        wr(`ETM_A_CTRL, 32'h1b);
        wr(`ETM_A_TXD, 32'h1ab);
        wirq(2000);
        tx_chk(2, 1, fcs);
        wr(`ETM_A_MASK, 32'h0);
        #1 chk("irq masked", irq_o, 32'h0);
        wr(`ETM_A_MASK, 32'h1);
        #1 chk("irq unmasked", irq_o, 32'h1);
        rc(`ETM_A_STAT, '1, 32'h1);
        chk("irq cleared", irq_o, 32'h0);
        wr(`ETM_A_MASK, 32'h2);
        wr(`ETM_A_TXD, 32'h0ab);
        wirq(2000);
        tx_chk(2, 1, ~fcs);
        rc(`ETM_A_STAT, 32'h2, 32'h2);
        // Half duplex waits out carrier
        phy.crs_o <= 1'b1;
        wr(`ETM_A_MASK, 32'h1);
        wr(`ETM_A_CTRL, 32'h0b);
        wr(`ETM_A_TXD, 32'h1ab);
        repeat (300) @(posedge core_clk_i);
        chk("deferred", 32'(phy.q.size()), 32'h0);
        phy.crs_o <= 1'b0;
        wirq(2000);
        tx_chk(2, 1, fcs);
        rc(`ETM_A_STAT, '1, 32'h1);
        wr(`ETM_A_CTRL, 32'h3d);
        wr(`ETM_A_TXD, 32'h1ab);
        repeat (300) @(posedge core_clk_i);
        chk("reduced held", 32'(phy.q.size()), 32'h0);
        wr(`ETM_A_CTRL, 32'h1d);
        wirq(2000);
        tx_chk(4, 1, fcs);
        rc(`ETM_A_STAT, '1, 32'h1);
        wr(`ETM_A_CTRL, 32'h15);
        wr(`ETM_A_TXD, 32'h1ab);
        wirq(9000);
        tx_chk(4, 10, fcs);
        rc(`ETM_A_STAT, '1, 32'h1);
        wr(`ETM_A_MASK, 32'h80);
        wr(`ETM_A_MDIO, 32'h0022a5c3);
        wirq(2000);
        chk("mdc count", 32'(phy.nmdc), 32'd65);
        chk("mdio frame", phy.sr, 32'h508aa5c3);
        rc(`ETM_A_STAT, '1, 32'h80);
        wr(`ETM_A_CTRL, 32'h1b);
        wr(`ETM_A_MASK, 32'h20);
        phy.rx_frame();
        wirq(500);
        rc(`ETM_A_STAT, '1, 32'h28);
        rc(`ETM_A_RXD, '1, 32'h13c);
        finish_test();
    end
endmodule
`default_nettype wire

// *** etm_crc32.sv ***
// Byte-wide CRC-32 register for frame check sequences
`timescale 1ns/10ps
`default_nettype none
`include "etm_defs.svh"
module etm_crc32 (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        init_i,
    input  wire logic        en_i,
    input  wire logic [7:0]  byte_i,
    output logic      [31:0] crc_o
);
    logic [31:0] crc_q;

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `ETM_CRC_POLY) : (r >> 1);
        return r;
    endfunction

    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
            crc_q <= `ETM_CRC_INIT;
        else if (init_i)
            crc_q <= `ETM_CRC_INIT;
        else if (en_i)
            crc_q <= crc_step(crc_q, byte_i);

    assign crc_o = crc_q;
endmodule
`default_nettype wire

// *** etm_defs.svh ***
// Register offsets, field positions, reset values and counts of the MAC front end
`ifndef ETM_DEFS_SVH
`define ETM_DEFS_SVH

`define ETM_A_CTRL   8'h00
`define ETM_A_STAT   8'h04
`define ETM_A_MASK   8'h08
`define ETM_A_TXD    8'h0c
`define ETM_A_RXD    8'h10
`define ETM_A_PAUSE  8'h14
`define ETM_A_MDIO   8'h18

`define ETM_C_TXEN   0
`define ETM_C_RXEN   1
`define ETM_C_RMII   2
`define ETM_C_SPD    3
`define ETM_C_FDX    4
`define ETM_C_RRST   5
`define ETM_CTRL_RST 6'h20

`define ETM_S_TXDONE 0
`define ETM_S_UFLOW  1
`define ETM_S_COLL   2
`define ETM_S_RXBYTE 3
`define ETM_S_RXOK   4
`define ETM_S_RXBAD  5
`define ETM_S_RXOVR  6
`define ETM_S_MDIO   7

`define ETM_T_LAST   8
`define ETM_T_PRIO   9
`define ETM_M_READ   26

`define ETM_MDC_HALF 3'd5
`define ETM_R10_DIV  4'd10
`define ETM_SLOT_MII 8'd127
`define ETM_SLOT_RMI 8'd255
`define ETM_PRE_LAST 3'd7
`define ETM_FCS_LAST 3'd3
`define ETM_MD_PRE   7'd32
`define ETM_MD_TA    7'd46
`define ETM_MD_SMP   7'd49
`define ETM_MD_END   7'd64

`define ETM_PRE      8'h55
`define ETM_SFD      8'hd5
`define ETM_CRC_INIT 32'hffffffff
`define ETM_CRC_POLY 32'hedb88320
`define ETM_CRC_RES  32'hdebb20e3

`endif

// *** etm_mac.sv ***
// MAC front end with full and reduced media independent interfaces and management port
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "etm_defs.svh"
module etm_mac (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    output logic             irq_o,
    input  wire logic        mii_tx_clk_i,
    input  wire logic        mii_rx_clk_i,
    input  wire logic        reduced_if_reference_clock_i,
    output logic      [3:0]  mii_txd_o,
    output logic             mii_tx_en_o,
    output logic             transmit_coding_error_pin_o,
    input  wire logic [3:0]  mii_rxd_i,
    input  wire logic        mii_rx_dv_i,
    input  wire logic        mii_rx_er_i,
    input  wire logic        mii_crs_i,
    input  wire logic        mii_col_i,
    output logic      [1:0]  rmii_txd_o,
    output logic             rmii_tx_en_o,
    input  wire logic [1:0]  rmii_rxd_i,
    input  wire logic        rmii_crs_dv_i,
    output logic             mdc_o,
    output logic             mdio_o,
    output logic             mdio_oe_n_o,
    input  wire logic        mdio_i
);
    // Pin synchronisers; index 0..2 are the three link clocks
    logic [14:0] pin_raw;
    logic [14:0] sync1_q;
    logic [14:0] sync2_q;
    logic [2:0]  clk_d_q;

    assign pin_raw = {mdio_i, rmii_crs_dv_i, rmii_rxd_i, mii_col_i, mii_crs_i,
                      mii_rx_er_i, mii_rx_dv_i, mii_rxd_i,
                      reduced_if_reference_clock_i, mii_rx_clk_i, mii_tx_clk_i};

    genvar g;
    generate
        for (g = 0; g < 15; g++)
        begin : g_sync
            always_ff @(posedge core_clk_i or negedge resetn_i)
                if (!resetn_i)
                begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                end
                else
                begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                end
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
            clk_d_q <= 3'h0;
        else
            clk_d_q <= sync2_q[2:0];

    // Registers
    logic [5:0]  ctrl_q;
    logic [7:0]  stat_q;
    logic [7:0]  mask_q;
    logic [9:0]  hold_q;
    logic        hold_vld_q;
    logic [7:0]  rx_byte_q;
    logic        rx_vld_q;
    logic [15:0] pause_q;
    logic [7:0]  slot_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;

    wire wr_ctrl  = reg_wr_i && reg_addr_i == `ETM_A_CTRL;
    wire wr_mask  = reg_wr_i && reg_addr_i == `ETM_A_MASK;
    wire wr_txd   = reg_wr_i && reg_addr_i == `ETM_A_TXD;
    wire wr_pause = reg_wr_i && reg_addr_i == `ETM_A_PAUSE;
    wire wr_mdio  = reg_wr_i && reg_addr_i == `ETM_A_MDIO;
    wire rd_stat  = reg_rd_i && reg_addr_i == `ETM_A_STAT;
    wire rd_rxd   = reg_rd_i && reg_addr_i == `ETM_A_RXD;

    // Mode decode; the mode bit steers both pin groups from one core
    wire rmii     = ctrl_q[`ETM_C_RMII];
    wire spd100   = ctrl_q[`ETM_C_SPD];
    wire rmii_act = rmii && !ctrl_q[`ETM_C_RRST];
    wire duplex   = rmii || ctrl_q[`ETM_C_FDX];

    // Link edges: transmit on rising, receive mid-bit on falling
    wire tx_rise  = sync2_q[0] && !clk_d_q[0];
    wire rx_fall  = !sync2_q[1] && clk_d_q[1];
    wire ref_rise = sync2_q[2] && !clk_d_q[2];
    wire ref_fall = !sync2_q[2] && clk_d_q[2];

    // At 10 Mbps each dibit repeats for ten reference cycles
    logic [3:0] div_q;
    wire div_ok   = spd100 || div_q == 4'h0;
    wire tx_tick  = rmii ? (rmii_act && ref_rise && div_ok) : tx_rise;
    wire rx_tick  = rmii ? (rmii_act && ref_fall && div_ok) : rx_fall;
    wire [1:0] unit_last = rmii ? 2'd3 : 2'd1;

    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
            div_q <= 4'h0;
        else if (!rmii_act)
            div_q <= 4'h0;
        else if (ref_rise)
            div_q <= (div_q == `ETM_R10_DIV - 4'd1) ? 4'h0 : div_q + 4'd1;

    // Transmit path
    etm_pkg::etm_tx_e tx_st_q;
    etm_pkg::etm_tx_e tx_st_d;
    logic [7:0]  tx_sh_q;
    logic [7:0]  tx_sh_d;
    logic [2:0]  tx_cnt_q;
    logic [2:0]  tx_cnt_d;
    logic [1:0]  tx_unit_q;
    logic [1:0]  tx_unit_d;
    logic [31:0] fcs_q;
    logic [31:0] fcs_d;
    logic        tx_last_q;
    logic        tx_last_d;
    logic [3:0]  txd_q;
    logic        tx_en_q;
    logic        tx_take;
    logic        tx_crc_init;
    logic        tx_uflow;
    logic        tx_done;
    logic        need_byte;
    logic [31:0] tx_crc;

    wire tx_idle  = tx_st_q == etm_pkg::TX_IDLE;
    wire pause_ok = pause_q == 16'h0 || hold_q[`ETM_T_PRIO];
    wire carr_ok  = duplex || !sync2_q[9];
    wire tx_go    = ctrl_q[`ETM_C_TXEN] && hold_vld_q && pause_ok && carr_ok;
    wire tx_abort = !rmii && !duplex && !tx_idle && sync2_q[10];
    wire unit_end = tx_unit_q == unit_last;

    always_comb
    begin
        tx_st_d     = tx_st_q;
        tx_sh_d     = tx_sh_q;
        tx_cnt_d    = tx_cnt_q;
        tx_unit_d   = tx_unit_q;
        fcs_d       = fcs_q;
        tx_last_d   = tx_last_q;
        tx_take     = 1'b0;
        tx_crc_init = 1'b0;
        tx_uflow    = 1'b0;
        tx_done     = 1'b0;
        need_byte   = 1'b0;
        if (tx_tick && tx_idle)
        begin
            if (tx_go)
            begin
                tx_st_d     = etm_pkg::TX_PRE;
                tx_sh_d     = `ETM_PRE;
                tx_cnt_d    = 3'h0;
                tx_unit_d   = 2'h0;
                tx_crc_init = 1'b1;
            end
        end
        else if (tx_tick && !unit_end)
        begin
            tx_unit_d = tx_unit_q + 2'd1;
            tx_sh_d   = rmii ? (tx_sh_q >> 2) : (tx_sh_q >> 4);
        end
        else if (tx_tick)
        begin
            tx_unit_d = 2'h0;
            case (tx_st_q)
                etm_pkg::TX_PRE:
                    if (tx_cnt_q == `ETM_PRE_LAST)
                        need_byte = 1'b1;
                    else
                    begin
                        tx_cnt_d = tx_cnt_q + 3'd1;
                        tx_sh_d  = (tx_cnt_q == `ETM_PRE_LAST - 3'd1) ? `ETM_SFD : `ETM_PRE;
                    end
                etm_pkg::TX_DATA:
                    if (tx_last_q)
                    begin
                        tx_st_d  = etm_pkg::TX_FCS;
                        tx_cnt_d = 3'h0;
                        fcs_d    = ~tx_crc;
                        tx_sh_d  = ~tx_crc[7:0];
                    end
                    else
                        need_byte = 1'b1;
                default:
                    if (tx_cnt_q == `ETM_FCS_LAST)
                    begin
                        tx_st_d = etm_pkg::TX_IDLE;
                        tx_done = 1'b1;
                    end
                    else
                    begin
                        tx_cnt_d = tx_cnt_q + 3'd1;
                        fcs_d    = fcs_q >> 8;
                        tx_sh_d  = fcs_q[15:8];
                    end
            endcase
            if (need_byte && hold_vld_q)
            begin
                tx_st_d   = etm_pkg::TX_DATA;
                tx_sh_d   = hold_q[7:0];
                tx_last_d = hold_q[`ETM_T_LAST];
                tx_take   = 1'b1;
            end
            else if (need_byte)
            begin
                // Starved mid-frame: close with a CRC receivers must reject
                tx_st_d  = etm_pkg::TX_FCS;
                tx_cnt_d = 3'h0;
                fcs_d    = tx_crc;
                tx_sh_d  = tx_crc[7:0];
                tx_uflow = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
        begin
            tx_st_q   <= etm_pkg::TX_IDLE;
            tx_sh_q   <= 8'h0;
            tx_cnt_q  <= 3'h0;
            tx_unit_q <= 2'h0;
            fcs_q     <= 32'h0;
            tx_last_q <= 1'b0;
            txd_q     <= 4'h0;
            tx_en_q   <= 1'b0;
        end
        else if (tx_abort || (rmii && !rmii_act))
        begin
            tx_st_q <= etm_pkg::TX_IDLE;
            tx_en_q <= 1'b0;
        end
        else
        begin
            tx_st_q   <= tx_st_d;
            tx_sh_q   <= tx_sh_d;
            tx_cnt_q  <= tx_cnt_d;
            tx_unit_q <= tx_unit_d;
            fcs_q     <= fcs_d;
            tx_last_q <= tx_last_d;
            if (tx_tick)
            begin
                tx_en_q <= !tx_idle;
                txd_q   <= tx_idle ? 4'h0 : (rmii ? {2'b00, tx_sh_q[1:0]} : tx_sh_q[3:0]);
            end
        end

    etm_crc32 u_tx_crc (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .init_i     (tx_crc_init),
        .en_i       (tx_take),
        .byte_i     (hold_q[7:0]),
        .crc_o      (tx_crc)
    );

    // Receive path
    etm_pkg::etm_rx_e rx_st_q;
    logic [7:0]  rx_sh_q;
    logic [1:0]  rx_unit_q;
    logic        rx_err_q;
    logic [31:0] rx_crc;

    wire       rx_dv   = rmii ? sync2_q[13] : sync2_q[7];
    wire [7:0] rx_sh_n = rmii ? {sync2_q[12:11], rx_sh_q[7:2]} : {sync2_q[6:3], rx_sh_q[7:4]};
    wire rx_on    = ctrl_q[`ETM_C_RXEN] && rx_tick && rx_dv;
    wire rx_sfd   = rx_on && rx_st_q == etm_pkg::RX_HUNT && rx_sh_n == `ETM_SFD;
    wire rx_byte  = rx_on && rx_st_q == etm_pkg::RX_DATA && rx_unit_q == unit_last;
    wire rx_end   = rx_tick && !rx_dv && rx_st_q == etm_pkg::RX_DATA;
    wire rx_good  = rx_crc == `ETM_CRC_RES && rx_unit_q == 2'h0 && !rx_err_q;

    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
        begin
            rx_st_q   <= etm_pkg::RX_IDLE;
            rx_sh_q   <= 8'h0;
            rx_unit_q <= 2'h0;
            rx_err_q  <= 1'b0;
        end
        else if (rx_tick && !rx_on)
            rx_st_q <= etm_pkg::RX_IDLE;
        else if (rx_on)
        begin
            rx_sh_q <= rx_sh_n;
            if (rx_st_q == etm_pkg::RX_IDLE)
                rx_st_q <= etm_pkg::RX_HUNT;
            else if (rx_sfd)
            begin
                rx_st_q   <= etm_pkg::RX_DATA;
                rx_unit_q <= 2'h0;
                rx_err_q  <= 1'b0;
            end
            else if (rx_st_q == etm_pkg::RX_DATA)
            begin
                rx_unit_q <= (rx_unit_q == unit_last) ? 2'h0 : rx_unit_q + 2'd1;
                if (sync2_q[8] && !rmii)
                    rx_err_q <= 1'b1;
            end
        end

    etm_crc32 u_rx_crc (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .init_i     (rx_sfd),
        .en_i       (rx_byte),
        .byte_i     (rx_sh_n),
        .crc_o      (rx_crc)
    );

    // Management serial engine, separate from packet flow
    logic [2:0]  mdiv_q;
    logic        md_busy_q;
    logic        mdc_q;
    logic        md_read_q;
    logic [6:0]  md_cnt_q;
    logic [31:0] md_sh_q;
    logic [15:0] md_rd_q;
    logic        mdo_q;
    logic        md_oe_n_q;

    wire md_half = md_busy_q && mdiv_q == `ETM_MDC_HALF - 3'd1;
    wire md_fall = md_half && mdc_q;
    wire md_done = md_fall && md_cnt_q == `ETM_MD_END;

    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
        begin
            mdiv_q    <= 3'h0;
            md_busy_q <= 1'b0;
            mdc_q     <= 1'b0;
            md_read_q <= 1'b0;
            md_cnt_q  <= 7'h0;
            md_sh_q   <= 32'h0;
            md_rd_q   <= 16'h0;
            mdo_q     <= 1'b1;
            md_oe_n_q <= 1'b1;
        end
        else if (wr_mdio && !md_busy_q)
        begin
            md_busy_q <= 1'b1;
            md_read_q <= reg_wdata_i[`ETM_M_READ];
            md_sh_q   <= {2'b01, reg_wdata_i[`ETM_M_READ] ? 2'b10 : 2'b01,
                          reg_wdata_i[25:16], 2'b10, reg_wdata_i[15:0]};
            md_cnt_q  <= 7'h0;
            mdiv_q    <= 3'h0;
        end
        else if (md_busy_q)
        begin
            mdiv_q <= md_half ? 3'h0 : mdiv_q + 3'd1;
            if (md_half)
                mdc_q <= !mdc_q;
            if (md_done)
            begin
                md_busy_q <= 1'b0;
                md_oe_n_q <= 1'b1;
                mdc_q     <= 1'b0;
            end
            else if (md_fall)
            begin
                mdo_q     <= (md_cnt_q < `ETM_MD_PRE) ? 1'b1 : md_sh_q[31];
                md_oe_n_q <= md_read_q && md_cnt_q >= `ETM_MD_TA;
                md_cnt_q  <= md_cnt_q + 7'd1;
                if (md_cnt_q >= `ETM_MD_PRE)
                    md_sh_q <= md_sh_q << 1;
            end
            else if (md_half && md_read_q && md_cnt_q >= `ETM_MD_SMP)
                md_rd_q <= {md_rd_q[14:0], sync2_q[14]};
        end

    // Events; set wins over the read that clears
    logic [7:0] ev;
    assign ev[`ETM_S_TXDONE] = tx_done;
    assign ev[`ETM_S_UFLOW]  = tx_uflow;
    assign ev[`ETM_S_COLL]   = tx_abort;
    assign ev[`ETM_S_RXBYTE] = rx_byte;
    assign ev[`ETM_S_RXOK]   = rx_end && rx_good;
    assign ev[`ETM_S_RXBAD]  = rx_end && !rx_good;
    assign ev[`ETM_S_RXOVR]  = rx_byte && rx_vld_q && !rd_rxd;
    assign ev[`ETM_S_MDIO]   = md_done;

    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
        begin
            ctrl_q     <= `ETM_CTRL_RST;
            stat_q     <= 8'h0;
            mask_q     <= 8'h0;
            hold_q     <= 10'h0;
            hold_vld_q <= 1'b0;
            rx_byte_q  <= 8'h0;
            rx_vld_q   <= 1'b0;
            pause_q    <= 16'h0;
            slot_q     <= 8'h0;
            rdata_q    <= 32'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= reg_wdata_i[5:0];
            if (wr_mask)
                mask_q <= reg_wdata_i[7:0];
            stat_q <= (rd_stat ? 8'h0 : stat_q) | ev;
            if (wr_txd && !hold_vld_q)
                hold_q <= reg_wdata_i[9:0];
            hold_vld_q <= (hold_vld_q && !tx_take) || (wr_txd && !hold_vld_q);
            if (rx_byte)
                rx_byte_q <= rx_sh_n;
            rx_vld_q <= (rx_vld_q && !rd_rxd) || rx_byte;
            // Pause counts down in slot times of 512 bits
            if (tx_tick)
                slot_q <= (slot_q == (rmii ? `ETM_SLOT_RMI : `ETM_SLOT_MII)) ? 8'h0 : slot_q + 8'd1;
            if (wr_pause)
                pause_q <= reg_wdata_i[15:0];
            else if (tx_tick && pause_q != 16'h0 &&
                     slot_q == (rmii ? `ETM_SLOT_RMI : `ETM_SLOT_MII))
                pause_q <= pause_q - 16'd1;
            rdata_q <= reg_rd_i ? rd_mux : 32'h0;
        end

    always_comb
    begin
        if (reg_addr_i == `ETM_A_CTRL)
            rd_mux = {26'h0, ctrl_q};
        else if (reg_addr_i == `ETM_A_STAT)
            rd_mux = {24'h0, stat_q};
        else if (reg_addr_i == `ETM_A_MASK)
            rd_mux = {24'h0, mask_q};
        else if (reg_addr_i == `ETM_A_TXD)
            rd_mux = {30'h0, !tx_idle, hold_vld_q};
        else if (reg_addr_i == `ETM_A_RXD)
            rd_mux = {23'h0, rx_vld_q, rx_byte_q};
        else if (reg_addr_i == `ETM_A_PAUSE)
            rd_mux = {16'h0, pause_q};
        else if (reg_addr_i == `ETM_A_MDIO)
            rd_mux = {15'h0, md_busy_q, md_rd_q};
        else
            rd_mux = 32'h0;
    end

    // Pin outputs; the idle mode's pins stay quiet
    assign reg_rdata_o = rdata_q;
    assign irq_o       = |(stat_q & mask_q);
    assign mii_txd_o   = rmii ? 4'h0 : txd_q;
    assign mii_tx_en_o = tx_en_q && !rmii;
    assign rmii_txd_o  = rmii ? txd_q[1:0] : 2'h0;
    assign rmii_tx_en_o = tx_en_q && rmii;
    assign transmit_coding_error_pin_o = 1'b0;
    assign mdc_o       = mdc_q;
    assign mdio_o      = mdo_q;
    assign mdio_oe_n_o = md_oe_n_q;
endmodule
`default_nettype wire

// *** etm_mac_properties.sv ***
// Port assertions of the MAC front end
`timescale 1ns/10ps
`default_nettype none
`include "etm_defs.svh"
module etm_mac_props (
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        irq_o,
    input wire logic [3:0]  mii_txd_o,
    input wire logic        mii_tx_en_o,
    input wire logic        transmit_coding_error_pin_o,
    input wire logic [1:0]  rmii_txd_o,
    input wire logic        rmii_tx_en_o,
    input wire logic        mdc_o,
    input wire logic        mdio_o,
    input wire logic        mdio_oe_n_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // High phase of the management clock is five core cycles
    sequence s_mdc_hi;
        mdc_o [*5] ##1 !mdc_o;
    endsequence
    AST_NO_TXER: assert property (transmit_coding_error_pin_o == 1'b0)
        else $error("coding error pin driven");
    AST_ONE_MODE: assert property (!(mii_tx_en_o && rmii_tx_en_o))
        else $error("both interfaces sending");
    AST_RD_STANDS: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
        else $error("read data outside its cycle");
    AST_MASK_OFF: assert property (reg_wr_i && reg_addr_i == `ETM_A_MASK
        && reg_wdata_i[7:0] == 8'h00 |=> !irq_o) else $error("irq despite mask");
    AST_MDC_HI: assert property ($rose(mdc_o) |-> s_mdc_hi)
        else $error("mdc high phase length");
    AST_MDIO_PRE: assert property ($fell(mdio_oe_n_o) |-> mdio_o)
        else $error("management frame not opening with ones");
    AST_MII_PRE: assert property ($rose(mii_tx_en_o) |-> mii_txd_o == 4'h5)
        else $error("full interface frame start");
    AST_RMII_PRE: assert property ($rose(rmii_tx_en_o) |-> rmii_txd_o == 2'h1)
        else $error("reduced interface frame start");
    AST_NIB_HOLD: assert property (mii_tx_en_o && $changed(mii_txd_o)
        |=> $stable(mii_txd_o) [*5]) else $error("nibble held too briefly");
endmodule
bind etm_mac etm_mac_props u_props (.core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .mii_txd_o, .mii_tx_en_o, .rmii_txd_o,
    .transmit_coding_error_pin_o, .rmii_tx_en_o, .mdc_o, .mdio_o, .mdio_oe_n_o);
`default_nettype wire

// *** etm_phy_model.sv ***
// Behavioural PHY: link clock, transmit capture, receive frame, management sink
`timescale 1ns/10ps
`default_nettype none
module etm_phy_model (
    output logic            lck_o,
    input  wire logic [3:0] txd_i,
    input  wire logic       tx_en_i,
    input  wire logic [1:0] rtxd_i,
    input  wire logic       rtx_en_i,
    output logic      [3:0] rxd_o,
    output logic            rx_dv_o,
    output logic            crs_o,
    output logic      [1:0] rrxd_o,
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    input  wire logic       mdio_oe_n_i,
    output logic            mdio_o
);
    logic [3:0]  q[$];
    logic [31:0] sr = 32'h0;
    int          nmdc = 0;
    initial
    begin
        {lck_o, rx_dv_o, crs_o, rxd_o, rrxd_o} = 9'h0;
        #7;
        forever #160 lck_o = ~lck_o;
    end
    // Read one edge after launch, once the MAC output has settled
    always @(posedge lck_o)
    begin
        rrxd_o <= rrxd_o + 2'h1;
        if (tx_en_i)
            q.push_back(txd_i);
        if (rtx_en_i)
            q.push_back({2'h0, rtxd_i});
    end
    // Pulled up while nobody drives the line
    assign mdio_o = mdio_oe_n_i ? 1'b1 : mdio_i;
    always @(posedge mdc_i)
    begin
        sr <= {sr[30:0], mdio_o};
        nmdc <= nmdc + 1;
    end
    task automatic rx_frame;
        for (int i = 0; i < 18; i++)
        begin
            @(posedge lck_o);
            rxd_o <= i < 15 ? 4'h5 : i == 15 ? 4'hd : i == 16 ? 4'hc : 4'h3;
            rx_dv_o <= 1'b1;
        end
        @(posedge lck_o);
        rx_dv_o <= 1'b0;
        rxd_o <= 4'hc;
    endtask
endmodule
`default_nettype wire

// *** etm_pkg.sv ***
// State types of the MAC front end
`default_nettype none
package etm_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_PRE  = 2'b01,
        TX_DATA = 2'b11,
        TX_FCS  = 2'b10
    } etm_tx_e;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_HUNT = 2'b01,
        RX_DATA = 2'b11
    } etm_rx_e;
endpackage
`default_nettype wire
